// ---- common/psq_pkg.sv ----
// constants and types for the program sequencer
package psq_pkg;
   localparam int PC_W = 12;
   localparam int INSN_W = 16;
   localparam int STACK_DEPTH = 8;
   localparam int SIDX_W = 3;
   localparam int PHASES = 4;
   localparam logic [11:0] RESET_VEC = 12'h000;
   localparam logic [11:0] VEC_EXT0 = 12'h004;
   localparam logic [11:0] VEC_EXT1 = 12'h008;
   localparam logic [11:0] VEC_TMR0 = 12'h00C;
   localparam logic [11:0] VEC_TMR1 = 12'h010;
   localparam logic [11:0] VEC_SER = 12'h014;
   localparam logic [11:0] VEC_MULTI = 12'h018;
   localparam int SST_SYS = 1024;
   localparam logic [10:0] SST_CYCLES = 11'(SST_SYS);
   localparam logic [1:0] PH_FETCH = 2'h0;
   localparam logic [1:0] PH_LAST = 2'h3;
   typedef enum logic [2:0] {
      PSQ_OP_NEXT = 3'h0,
      PSQ_OP_SKIP = 3'h1,
      PSQ_OP_JUMP = 3'h2,
      PSQ_OP_CALL = 3'h3,
      PSQ_OP_RET = 3'h4,
      PSQ_OP_LOW = 3'h5
   } psq_op_t;
   typedef enum logic [1:0] {
      PSQ_ST_START = 2'h0,
      PSQ_ST_RUN = 2'h1,
      PSQ_ST_HALT = 2'h2
   } psq_state_t;
endpackage

// ---- verilog/psq_phase_gen.sv ----
// four-phase generator for the instruction cycle
`timescale 1ns/10ps
`default_nettype none
module psq_phase_gen (
   input wire logic clk,
   input wire logic nrst,
   input wire logic run,
   output logic [1:0] phase,
   output logic cycle_end
);
   logic [1:0] phase_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phase_q <= 2'h0;
      end else if (!run) begin
         phase_q <= 2'h0;
      end else begin
         phase_q <= phase_q + 2'h1;
      end
   end

   assign phase = phase_q;
   assign cycle_end = run && (phase_q == psq_pkg::PH_LAST);
endmodule
`default_nettype wire

// ---- verilog/psq_sequencer.sv ----
// program sequencer: pc, prefetch pipeline, return stack, start-up delay
`timescale 1ns/10ps
`default_nettype none
module psq_sequencer (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [15:0] rom_data,
   output logic [11:0] rom_addr,
   output logic rom_rd,
   output logic [15:0] insn,
   output logic insn_valid,
   output logic exec_strobe,
   input wire psq_pkg::psq_op_t op,
   input wire logic skip_taken,
   input wire logic [11:0] jump_target,
   input wire logic [7:0] counter_low_byte,
   input wire logic [5:0] irq_req,
   output logic irq_ack,
   output logic [2:0] irq_src,
   input wire logic halt_req,
   input wire logic wake,
   output logic halted,
   output logic running,
   output logic [11:0] pc,
   output logic [2:0] stack_index,
   output logic stack_full
);
   ////////////////////////////////////////////////////////////////////
   logic [1:0] phase;
   logic cycle_end;
   psq_pkg::psq_state_t state_q;
   logic [10:0] sst_q;
   logic [11:0] pc_q;
   logic [11:0] pc_d;
   logic [15:0] insn_q;
   logic valid_q;
   logic [11:0] stack_q [psq_pkg::STACK_DEPTH];
   logic [2:0] sidx_q;
   logic [3:0] depth_q;
   logic ack_q;
   logic [2:0] src_q;
   logic irq_take;
   logic [2:0] irq_pick;
   logic [11:0] irq_vec;
   logic transfer;
   logic push;
   logic pop;
   logic run;

   assign run = (state_q == psq_pkg::PSQ_ST_RUN);

   psq_phase_gen u_phase (
      .clk(clk),
      .nrst(nrst),
      .run(run),
      .phase(phase),
      .cycle_end(cycle_end)
   );

   ////////////////////////////////////////////////////////////////////
   // start-up delay
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= psq_pkg::PSQ_ST_START;
         sst_q <= 11'h000;
      end else begin
         unique case (state_q)
            psq_pkg::PSQ_ST_START: begin
               if (sst_q == psq_pkg::SST_CYCLES - 11'h001) begin
                  state_q <= psq_pkg::PSQ_ST_RUN;
                  sst_q <= 11'h000;
               end else begin
                  sst_q <= sst_q + 11'h001;
               end
            end
            psq_pkg::PSQ_ST_RUN: begin
               if (halt_req && cycle_end) begin
                  state_q <= psq_pkg::PSQ_ST_HALT;
               end
            end
            psq_pkg::PSQ_ST_HALT: begin
               if (wake) begin
                  state_q <= psq_pkg::PSQ_ST_START;
               end
            end
            default: begin
               state_q <= psq_pkg::PSQ_ST_START;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // interrupt priority: lowest index wins; blocked while stack is full
   always_comb begin
      irq_pick = 3'h0;
      for (int i = 5; i >= 0; i--) begin
         if (irq_req[i]) begin
            irq_pick = 3'(i);
         end
      end
   end

   always_comb begin
      unique case (irq_pick)
         3'h0: irq_vec = psq_pkg::VEC_EXT0;
         3'h1: irq_vec = psq_pkg::VEC_EXT1;
         3'h2: irq_vec = psq_pkg::VEC_TMR0;
         3'h3: irq_vec = psq_pkg::VEC_TMR1;
         3'h4: irq_vec = psq_pkg::VEC_SER;
         default: irq_vec = psq_pkg::VEC_MULTI;
      endcase
   end

   // an interrupt replaces the next instruction only after a plain execute slot
   assign irq_take = cycle_end && valid_q && (|irq_req) && (depth_q < 4'h8)
                     && (op == psq_pkg::PSQ_OP_NEXT || (op == psq_pkg::PSQ_OP_SKIP && !skip_taken));

   ////////////////////////////////////////////////////////////////////
   // next counter value at the end of the instruction cycle
   always_comb begin
      pc_d = pc_q;
      transfer = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      if (irq_take) begin
         // vector load, pc of the unexecuted prefetch is pushed
         pc_d = irq_vec;
         transfer = 1'b1;
         push = 1'b1;
      end else if (valid_q) begin
         unique case (op)
            psq_pkg::PSQ_OP_SKIP: begin
               // skip discards the prefetch fetched from pc; pc steps by one past it
               pc_d = pc_q + 12'h001;
               transfer = skip_taken;
            end
            psq_pkg::PSQ_OP_JUMP: begin
               pc_d = jump_target;
               transfer = 1'b1;
            end
            psq_pkg::PSQ_OP_CALL: begin
               pc_d = jump_target;
               transfer = 1'b1;
               push = 1'b1;
            end
            psq_pkg::PSQ_OP_RET: begin
               pc_d = stack_q[sidx_q - 3'h1];
               transfer = 1'b1;
               pop = 1'b1;
            end
            psq_pkg::PSQ_OP_LOW: begin
               pc_d = {pc_q[11:8], counter_low_byte};
               transfer = 1'b1;
            end
            default: begin
               pc_d = pc_q + 12'h001;
            end
         endcase
      end else begin
         pc_d = pc_q + 12'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // twelve-bit counter; transfer refetches, dummy slot follows
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pc_q <= psq_pkg::RESET_VEC;
      end else if (cycle_end) begin
         pc_q <= pc_d;
      end
   end

   // prefetch is kept through halt so the word after the halt runs on wake
   // prefetch register, invalid after reset and transfer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         insn_q <= 16'h0000;
         valid_q <= 1'b0;
      end else if (cycle_end) begin
         insn_q <= rom_data;
         valid_q <= !transfer;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // eight-level return stack, oldest entry overwritten on overflow
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sidx_q <= 3'h0;
         depth_q <= 4'h0;
      end else if (cycle_end) begin
         if (push) begin
            sidx_q <= sidx_q + 3'h1;
            depth_q <= (depth_q == 4'h8) ? 4'h8 : depth_q + 4'h1;
         end else if (pop) begin
            sidx_q <= sidx_q - 3'h1;
            depth_q <= (depth_q == 4'h0) ? 4'h0 : depth_q - 4'h1;
         end
      end
   end

   generate
      for (genvar g = 0; g < psq_pkg::STACK_DEPTH; g++) begin : g_stack
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               stack_q[g] <= 12'h000;
            end else if (cycle_end && push && sidx_q == 3'(g)) begin
               stack_q[g] <= pc_q;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ack_q <= 1'b0;
         src_q <= 3'h0;
      end else begin
         ack_q <= irq_take;
         if (irq_take) begin
            src_q <= irq_pick;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign rom_addr = pc_q;
   assign rom_rd = run && (phase == psq_pkg::PH_LAST);
   assign insn = insn_q;
   assign insn_valid = valid_q;
   assign exec_strobe = cycle_end && valid_q;
   assign irq_ack = ack_q;
   assign irq_src = src_q;
   assign halted = (state_q == psq_pkg::PSQ_ST_HALT);
   assign running = run;
   assign pc = pc_q;
   assign stack_index = sidx_q;
   assign stack_full = (depth_q == 4'h8);

   ////////////////////////////////////////////////////////////////////
   property p_cycle_len;
      @(posedge clk) disable iff (!nrst)
      (run && phase == 2'h0) |-> ##3 cycle_end;
   endproperty
   a_cycle_len: assert property (p_cycle_len) else $error("cycle not four clocks");

   property p_pc_inc;
      @(posedge clk) disable iff (!nrst)
      (cycle_end && !transfer && op != psq_pkg::PSQ_OP_SKIP) |=> pc_q == $past(pc_q) + 12'h001;
   endproperty
   a_pc_inc: assert property (p_pc_inc) else $error("pc did not advance by one");

   property p_jump;
      @(posedge clk) disable iff (!nrst)
      (cycle_end && valid_q && !irq_take && op == psq_pkg::PSQ_OP_JUMP) |=> pc_q == $past(jump_target);
   endproperty
   a_jump: assert property (p_jump) else $error("jump target not loaded");

   property p_low;
      @(posedge clk) disable iff (!nrst)
      (cycle_end && valid_q && !irq_take && op == psq_pkg::PSQ_OP_LOW)
      |=> pc_q == {$past(pc_q[11:8]), $past(counter_low_byte)};
   endproperty
   a_low: assert property (p_low) else $error("low byte write wrong");

   property p_dummy;
      @(posedge clk) disable iff (!nrst)
      (cycle_end && transfer) |=> !valid_q [*4];
   endproperty
   a_dummy: assert property (p_dummy) else $error("no dummy cycle after transfer");

   property p_vec;
      @(posedge clk) disable iff (!nrst)
      irq_take |=> (pc_q[11:5] == 7'h00) && (pc_q[1:0] == 2'h0);
   endproperty
   a_vec: assert property (p_vec) else $error("vector bits not zero");

   property p_sst;
      @(posedge clk) disable iff (!nrst)
      $rose(state_q == psq_pkg::PSQ_ST_START) |-> !run [*8];
   endproperty
   a_sst: assert property (p_sst) else $error("ran during start-up delay");

   property p_push;
      @(posedge clk) disable iff (!nrst)
      (cycle_end && push) |=> sidx_q == $past(sidx_q) + 3'h1;
   endproperty
   a_push: assert property (p_push) else $error("stack not pushed");
endmodule
`default_nettype wire

// ---- test/psq_rom_model.sv ----
// program memory stand-in: each word carries its own address
`timescale 1ns/10ps
`default_nettype none
module psq_rom_model (
   input wire logic [11:0] rom_addr,
   input wire logic rom_rd,
   output logic [15:0] rom_data
);
   // off the read strobe the bus floats, so show the inverse
   assign rom_data = rom_rd ? {4'hA, rom_addr} : ~{4'hA, rom_addr};
endmodule
`default_nettype wire

// ---- test/program_sequencer_tb.sv ----
// self-checking bench for the program sequencer
`timescale 1ns/10ps
`default_nettype none
module program_sequencer_tb;
   logic clk, nrst, rom_rd, iv, xs, sk, ack, hreq, wake, halted, running, full;
   logic [15:0] rom_data, insn, i0;
   logic [11:0] rom_addr, tgt, pc, p0, s;
   logic [7:0] lb;
   logic [5:0] irq;
   logic [2:0] src, sidx, asrc, d;
   psq_pkg::psq_op_t op;
   int failures = 0, comparisons = 0, cycles = 0, n0, acks = 0, a;
   logic [11:0] ret_a [8];

   psq_rom_model psq_rom_model_inst (.rom_addr(rom_addr), .rom_rd(rom_rd), .rom_data(rom_data));
   psq_sequencer psq_sequencer_inst (.clk(clk), .nrst(nrst), .rom_data(rom_data), .rom_addr(rom_addr),
      .rom_rd(rom_rd), .insn(insn), .insn_valid(iv), .exec_strobe(xs), .op(op), .skip_taken(sk),
      .jump_target(tgt), .counter_low_byte(lb), .irq_req(irq), .irq_ack(ack), .irq_src(src),
      .halt_req(hreq), .wake(wake), .halted(halted), .running(running), .pc(pc),
      .stack_index(sidx), .stack_full(full));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 12000) begin
         failures++;
         complete_run();
      end
   end
   always @(negedge clk) begin
      if (ack === 1'b1) begin
         acks++;
         asrc = src;
      end
   end
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // present one instruction and wait for its execute edge
   task automatic ex(input psq_pkg::psq_op_t o, input logic k, input logic [11:0] t,
         input logic [7:0] b, input logic [5:0] q);
      @(posedge clk);
      op <= o;
      sk <= k;
      tgt <= t;
      lb <= b;
      irq <= q;
      n0 = 0;
      @(negedge clk);
      while (xs !== 1'b1 && n0 < 40) begin
         @(negedge clk);
         n0++;
      end
      chk("strobe", 16'h0001, {15'h0000, xs});
      p0 = pc;
      i0 = insn;
      @(posedge clk);
      #1;
   endtask
   task automatic nx();
      ex(psq_pkg::PSQ_OP_NEXT, 1'b0, 12'h000, 8'h00, 6'h00);
   endtask
   task automatic wait_run(input string what);
      int n;
      n = 0;
      while (running !== 1'b1 && n < 1100) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(what, 16'h0001, 16'(n >= 1022 && n <= 1026));
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_boot();
      wait_run("startup");
      nx();
      chk("first word", 16'hA000, i0);
      chk("first pc", 16'h0001, p0);
      for (int j = 0; j < 3; j++) begin
         nx();
         chk("gap", 16'h0002, 16'(n0));
         chk("word", {4'hA, p0 - 12'h001}, i0);
         chk("pc", p0 + 12'h001, pc);
      end
      $display("boot done");
   endtask
   task automatic t_flow();
      ex(psq_pkg::PSQ_OP_JUMP, 1'b0, 12'hABC, 8'h00, 6'h00);
      chk("jump pc", 16'h0ABC, pc);
      chk("dummy", 16'h0000, iv);
      nx();
      chk("jump gap", 16'h0006, 16'(n0));
      chk("jump word", 16'hAABC, i0);
      ex(psq_pkg::PSQ_OP_LOW, 1'b0, 12'h000, 8'h3C, 6'h00);
      chk("low pc", 16'h0A3C, pc);
      nx();
      chk("low gap", 16'h0006, 16'(n0));
      ex(psq_pkg::PSQ_OP_SKIP, 1'b0, 12'h000, 8'h00, 6'h00);
      chk("no skip", 16'h0001, iv);
      ex(psq_pkg::PSQ_OP_SKIP, 1'b1, 12'h000, 8'h00, 6'h00);
      s = p0;
      chk("skip pc", s + 12'h001, pc);
      chk("skip dummy", 16'h0000, iv);
      nx();
      chk("skip word", {4'hA, s + 12'h001}, i0);
      d = sidx;
      ex(psq_pkg::PSQ_OP_CALL, 1'b0, 12'h5F0, 8'h00, 6'h00);
      s = p0;
      chk("call pc", 16'h05F0, pc);
      chk("push", d + 3'h1, sidx);
      nx();
      ex(psq_pkg::PSQ_OP_RET, 1'b0, 12'h000, 8'h00, 6'h00);
      chk("ret pc", s, pc);
      chk("pop", d, sidx);
      $display("flow done");
   endtask
   task automatic t_irq();
      for (int k = 0; k < 6; k++) begin
         a = acks;
         d = sidx;
         ex(psq_pkg::PSQ_OP_NEXT, 1'b0, 12'h000, 8'h00, 6'h3F << k);
         s = p0;
         chk("vector", 16'((k + 1) * 4), pc);
         nx();
         chk("ack", 16'(a + 1), 16'(acks));
         chk("src", 16'(k), asrc);
         chk("irq push", d + 3'h1, sidx);
         ex(psq_pkg::PSQ_OP_RET, 1'b0, 12'h000, 8'h00, 6'h00);
         chk("irq ret", s, pc);
      end
      $display("irq done");
   endtask
   task automatic t_stack();
      for (int j = 0; j < 8; j++) begin
         ex(psq_pkg::PSQ_OP_CALL, 1'b0, 12'h200 + 12'(j), 8'h00, 6'h00);
         ret_a[j] = p0;
      end
      chk("full", 16'h0001, full);
      a = acks;
      ex(psq_pkg::PSQ_OP_NEXT, 1'b0, 12'h000, 8'h00, 6'h01);
      chk("held pc", p0 + 12'h001, pc);
      chk("no ack", 16'(a), 16'(acks));
      for (int j = 7; j >= 0; j--) begin
         ex(psq_pkg::PSQ_OP_RET, 1'b0, 12'h000, 8'h00, 6'h00);
         chk("unwind", ret_a[j], pc);
      end
      $display("stack done");
   endtask
   task automatic t_halt();
      int n;
      @(posedge clk);
      hreq <= 1'b1;
      n = 0;
      while (halted !== 1'b1 && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("halt flag", 16'h0001, {15'h0000, halted});
      chk("halted", 16'h0000, running);
      s = pc;
      @(posedge clk);
      hreq <= 1'b0;
      wake <= 1'b1;
      wait_run("wake delay");
      wake <= 1'b0;
      nx();
      chk("resume", 16'h0001, 16'(n0 < 40));
      chk("resume gap", 16'h0002, 16'(n0));
      chk("resume word", {4'hA, s - 12'h001}, i0);
      $display("halt done");
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      nrst = 1'b0;
      op = psq_pkg::PSQ_OP_NEXT;
      sk = 1'b0;
      tgt = 12'h000;
      lb = 8'h00;
      irq = 6'h00;
      hreq = 1'b0;
      wake = 1'b0;
      repeat (10) @(posedge clk);
      chk("reset pc", 16'h0000, pc);
      chk("reset valid", 16'h0000, iv);
      nrst <= 1'b1;
      t_boot();
      t_flow();
      t_irq();
      t_stack();
      t_halt();
      complete_run();
   end
endmodule
`default_nettype wire
